/* design/mem_tester.sv */
// one memory under test with its write/read-back pattern engine
`timescale 1ns/1ps
`default_nettype none
module mem_tester
    import stc_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32
)(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // control
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] limit,
    input  wire logic             write_en,
    // result
    output logic                  done,
    output logic                  fail
);
    import stc_pkg::*;

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CNT_W-1:0]            cnt;
        logic                        run;
        logic                        done;
        logic                        fail;
    } tester_state_t;

    tester_state_t r, n;

    function automatic logic [WIDTH-1:0] pattern(input logic [AW-1:0] a);
        return {(WIDTH/8){PATTERN_SEED}} ^ {{(WIDTH-AW){1'b0}}, a};
    endfunction

    always_comb
    begin
        n = r;
        if (start && !r.run && !r.done)
        begin
            n.run  = 1'b1;
            n.cnt  = '0;
            n.fail = 1'b0;
        end
        else if (r.run)
        begin
            // write pass, then read-back pass, then idle to the fixed length
            if (r.cnt < CNT_W'(DEPTH))
            begin
                if (write_en)
                    n.mem[r.cnt[AW-1:0]] = pattern(r.cnt[AW-1:0]);
            end
            else if (r.cnt < CNT_W'(2 * DEPTH))
            begin
                if (r.mem[r.cnt[AW-1:0]] != pattern(r.cnt[AW-1:0]))
                    n.fail = 1'b1;
            end
            if (r.cnt == limit - 1'b1)
            begin
                n.run  = 1'b0;
                n.done = 1'b1;
            end
            n.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= n;
    end

    assign done = r.done;
    assign fail = r.fail;
endmodule
`default_nettype wire

/* design/self_test_device.sv */
// self-test control/status register and memory test sequencing
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - bit 0 enables receiver wrong-parity detection
// - bit 5 picks receiver test clock mode
// - transmitter test starts on bit 6 rising
// - label matrix test starts on bit 7 rising
// - bits 8-10 show transmitter test completion
// - bits 11-13 give transmitter pass/fail
// - bit 14 shows label matrix test completion
// - bit 15 gives label matrix pass/fail
// - testing overwrites the tested memory contents
// - only one self-test run per reset
// - transmitter test lasts 710 clock periods
// - label matrix test 2820 or 5640 periods
// - software polls, then rereads for results
// - parity flag sets only when enabled
// - reset clears registers, lasts over 4 cycles
module self_test_device
    import stc_pkg::*;
#(
    parameter int RX_LONG_CYCLES = RX_LONG_CYC
)(
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // register port
    stc_link_if.device link,
    // receiver parity events
    input  wire logic  rx_parity_error,
    input  wire logic  wrong_parity_clear,
    output logic       parity_detect_enable,
    output logic       wrong_parity_flag
);
    import stc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        // command bits
        logic        par_en;
        logic        clk_mode;
        logic        tx_bit;
        logic        rx_bit;
        // run bookkeeping
        logic        used;
        logic        tx_go;
        logic        rx_go;
        // port answer
        logic        ack;
        logic [15:0] rdata;
        // parity status
        logic        par_flag;
    } device_state_t;

    device_state_t r;
    device_state_t n;

    // tester results
    logic [TX_CHANNELS-1:0] tx_done;
    logic [TX_CHANNELS-1:0] tx_fail;
    logic                   rx_done;
    logic                   rx_fail;
    logic [CNT_W-1:0]       rx_limit;
    logic                   lcm_we_all;

    // register decode
    logic                   hit;
    logic                   wr_hit;
    logic                   tx_rise;
    logic                   rx_rise;

    // ----------------------------------------
    // memories under test
    // ----------------------------------------
    // one tester per transmitter fifo
    genvar g;
    generate
        for (g = 0; g < TX_CHANNELS; g++)
        begin : g_fifo
            mem_tester #(
                .DEPTH (FIFO_DEPTH),
                .WIDTH (FIFO_WIDTH)
            ) u_fifo (
                .pclk     (pclk),
                .presetn  (presetn),
                .start    (r.tx_go),
                .limit    (TX_TEST_CYC),
                .write_en (1'b1),
                .done     (tx_done[g]),
                .fail     (tx_fail[g])
            );
        end
    endgenerate

    // long count in the faster clock mode
    assign rx_limit   = r.clk_mode ? CNT_W'(RX_LONG_CYCLES) : RX_TEST_CYC;
    // cells are only written when every receiver allows it
    assign lcm_we_all = &link.label_matrix_write_enable;

    mem_tester #(
        .DEPTH (LCM_DEPTH),
        .WIDTH (LCM_WIDTH)
    ) u_lcm (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (r.rx_go),
        .limit    (rx_limit),
        .write_en (lcm_we_all),
        .done     (rx_done),
        .fail     (rx_fail)
    );

    // ----------------------------------------
    // register access
    // ----------------------------------------
    // start fires only on a 0-to-1 write
    function automatic logic start_edge(input logic wr_now, input logic bit_new,
                                        input logic bit_old);
        return wr_now && bit_new && !bit_old;
    endfunction

    assign hit     = link.sel && !r.ack && (link.addr == ST_ADDR);
    assign wr_hit  = hit && link.wr;
    assign tx_rise = start_edge(wr_hit, link.wdata[B_TX_START], r.tx_bit);
    assign rx_rise = start_edge(wr_hit, link.wdata[B_RX_START], r.rx_bit);

    always_comb
    begin
        n       = r;
        n.tx_go = 1'b0;
        n.rx_go = 1'b0;
        n.ack   = hit;

        // ----------------------------------------
        // command write
        // ----------------------------------------
        if (wr_hit)
        begin
            n.par_en   = link.wdata[B_PAR_EN];
            n.clk_mode = link.wdata[B_CLK_MODE];
            n.tx_bit   = link.wdata[B_TX_START];
            n.rx_bit   = link.wdata[B_RX_START];
            // both starts of one write form a single run
            if (!r.used && (tx_rise || rx_rise))
            begin
                n.used  = 1'b1;
                n.tx_go = tx_rise;
                n.rx_go = rx_rise;
            end
        end

        // ----------------------------------------
        // status readback
        // ----------------------------------------
        if (hit && !link.wr)
        begin
            n.rdata               = ST_RESET;
            n.rdata[B_PAR_EN]     = r.par_en;
            n.rdata[B_CLK_MODE]   = r.clk_mode;
            n.rdata[B_TX_START]   = r.tx_bit;
            n.rdata[B_RX_START]   = r.rx_bit;
            n.rdata[B_TX_DONE +: TX_CHANNELS] = tx_done;
            n.rdata[B_TX_FAIL +: TX_CHANNELS] = tx_fail;
            n.rdata[B_RX_DONE]    = rx_done;
            n.rdata[B_RX_FAIL]    = rx_fail;
        end

        // ----------------------------------------
        // receiver parity
        // ----------------------------------------
        // event wins over a clear in the same cycle
        if (wrong_parity_clear)
        begin
            n.par_flag = 1'b0;
        end
        if (rx_parity_error && r.par_en)
        begin
            n.par_flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign link.rdata                = r.rdata;
    assign link.transfer_acknowledge = r.ack;
    assign parity_detect_enable      = r.par_en;
    assign wrong_parity_flag         = r.par_flag;
endmodule
`default_nettype wire

/* design/self_test_host.sv */
// host controller: apb registers in, self-test sequence out on the register port
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module self_test_host
    import stc_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // register port
    stc_link_if.host         link
);
    import stc_pkg::*;

    typedef struct packed {
        host_state_t st;
        logic        sel;
        logic        wr;
        logic [15:0] wdata;
        logic [7:0]  lmwe;
        logic        par_en;
        logic        mode;
        logic        want_tx;
        logic        want_rx;
        logic        used;
        logic        busy;
        logic [15:0] result;
        logic [1:0]  sts;
        logic [1:0]  msk;
        logic        pready;
        logic [31:0] prdata;
        logic        irq;
    } host_state_s_t;

    host_state_s_t r, n;
    logic          acc;
    logic [1:0]    ev;
    logic          ended;

    assign acc = psel && penable && r.pready;
    assign ended = (!r.want_tx || &link.rdata[B_TX_DONE +: TX_CHANNELS])
                && (!r.want_rx || link.rdata[B_RX_DONE]);

    always_comb
    begin
        n        = r;
        ev       = 2'b00;
        n.pready = psel && penable && !r.pready;
        // ----------------------------------------
        // apb registers
        // ----------------------------------------
        if (n.pready)
        begin
            case (paddr)
                H_STATUS:  n.prdata = {r.result, 14'h0000, r.used, r.busy};
                H_CTRL:    n.prdata = {28'h0000000, r.want_rx, r.want_tx, r.mode, r.par_en};
                H_IRQ_STS: n.prdata = {30'h0, r.sts};
                H_IRQ_MSK: n.prdata = {30'h0, r.msk};
                default:   n.prdata = 32'h00000000;
            endcase
        end
        if (acc && pwrite && paddr == H_IRQ_MSK)
            n.msk = pwdata[1:0];
        if (acc && pwrite && paddr == H_CTRL && r.st == H_IDLE)
        begin
            n.par_en = pwdata[C_PAR_EN];
            n.mode   = pwdata[C_CLK_MODE];
            n.want_tx = 1'b0;
            n.want_rx = 1'b0;
            if (pwdata[C_RUN_TX] || pwdata[C_RUN_RX])
            begin
                if (r.used)
                    ev[I_REFUSED] = 1'b1;
                else
                begin
                    n.used    = 1'b1;
                    n.busy    = 1'b1;
                    n.want_tx = pwdata[C_RUN_TX];
                    n.want_rx = pwdata[C_RUN_RX];
                    n.st      = H_WR_CFG;
                end
            end
            else
                n.st = H_WR_CFG;
        end
        // ----------------------------------------
        // register port sequence
        // ----------------------------------------
        if (r.st != H_IDLE && !r.sel)
        begin
            n.sel = 1'b1;
            n.wr  = !(r.st == H_POLL || r.st == H_RESULT);
            case (r.st)
                H_WR_CFG: n.wdata = cfg_word(r.par_en, r.mode, 1'b0, 1'b0);
                H_WR_GO:  n.wdata = cfg_word(r.par_en, r.mode, r.want_tx, r.want_rx);
                default:  n.wdata = cfg_word(r.par_en, r.mode, 1'b0, 1'b0);
            endcase
            if (r.st == H_WR_CFG && r.want_rx)
                n.lmwe = 8'hFF;
        end
        else if (r.sel && link.transfer_acknowledge)
        begin
            n.sel = 1'b0;
            case (r.st)
                H_WR_CFG: n.st = (r.want_tx || r.want_rx) ? H_WR_GO : H_IDLE;
                H_WR_GO:  n.st = H_POLL;
                H_POLL:   n.st = ended ? H_RESULT : H_POLL;
                H_RESULT:
                begin
                    n.result = link.rdata;
                    n.st     = H_WR_CLR;
                end
                H_WR_CLR:
                begin
                    n.busy       = 1'b0;
                    ev[I_DONE]   = 1'b1;
                    n.st         = H_IDLE;
                end
                default:  n.st = H_IDLE;
            endcase
        end
        // set wins over a write-one clear
        if (acc && pwrite && paddr == H_IRQ_STS)
            n.sts = r.sts & ~pwdata[1:0];
        n.sts = n.sts | ev;
        n.irq = |(n.sts & n.msk);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= '0;
        else
            r <= n;
    end

    assign pready                         = r.pready;
    assign prdata                         = r.prdata;
    assign pslverr                        = 1'b0;
    assign irq                            = r.irq;
    assign link.sel                       = r.sel;
    assign link.wr                        = r.wr;
    assign link.addr                      = ST_ADDR;
    assign link.wdata                     = r.wdata;
    assign link.label_matrix_write_enable = r.lmwe;
endmodule
`default_nettype wire

/* design/stc_link_if.sv */
// register port joining the host controller and the self-test block
`timescale 1ns/1ps
`default_nettype none
interface stc_link_if;
    logic        sel;
    logic        wr;
    logic [8:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        transfer_acknowledge;
    logic [7:0]  label_matrix_write_enable;

    modport device (
        input  sel,
        input  wr,
        input  addr,
        input  wdata,
        input  label_matrix_write_enable,
        output rdata,
        output transfer_acknowledge
    );
    modport host (
        output sel,
        output wr,
        output addr,
        output wdata,
        output label_matrix_write_enable,
        input  rdata,
        input  transfer_acknowledge
    );
endinterface
`default_nettype wire

/* design/stc_pkg.sv */
// shared constants and types for the memory self-test controller and its host
package stc_pkg;
    // ----------------------------------------
    // device register map and field positions
    // ----------------------------------------
    localparam logic [8:0] ST_ADDR      = 9'h043;
    localparam int         B_PAR_EN     = 0;
    localparam int         B_CLK_MODE   = 5;
    localparam int         B_TX_START   = 6;
    localparam int         B_RX_START   = 7;
    localparam int         B_TX_DONE    = 8;
    localparam int         B_TX_FAIL    = 11;
    localparam int         B_RX_DONE    = 14;
    localparam int         B_RX_FAIL    = 15;
    localparam logic [15:0] ST_RESET    = 16'h0000;
    // ----------------------------------------
    // test geometry and timing
    // ----------------------------------------
    localparam int         TX_CHANNELS  = 3;
    localparam int         FIFO_DEPTH   = 8;
    localparam int         FIFO_WIDTH   = 32;
    localparam int         LCM_DEPTH    = 256;
    localparam int         LCM_WIDTH    = 16;
    localparam int         RX_CHANNELS  = 8;
    localparam int         CLK_MHZ      = 10;
    localparam int         CNT_W        = 13;
    localparam logic [12:0] TX_TEST_CYC = 13'h2C6;
    localparam logic [12:0] RX_TEST_CYC = 13'hB04;
    localparam int         RX_LONG_CYC  = 5640;
    localparam logic [7:0] PATTERN_SEED = 8'h5A;
    // ----------------------------------------
    // host register map (apb byte addresses)
    // ----------------------------------------
    localparam logic [7:0] H_CTRL       = 8'h00;
    localparam logic [7:0] H_STATUS     = 8'h04;
    localparam logic [7:0] H_IRQ_STS    = 8'h08;
    localparam logic [7:0] H_IRQ_MSK    = 8'h0C;
    localparam int         C_PAR_EN     = 0;
    localparam int         C_CLK_MODE   = 1;
    localparam int         C_RUN_TX     = 2;
    localparam int         C_RUN_RX     = 3;
    localparam int         I_DONE       = 0;
    localparam int         I_REFUSED    = 1;

    typedef enum logic [2:0] {
        H_IDLE, H_WR_CFG, H_WR_GO, H_POLL, H_RESULT, H_WR_CLR
    } host_state_t;

    // self-test word as the host writes it
    function automatic logic [15:0] cfg_word(input logic par, input logic mode,
                                             input logic tx, input logic rx);
        logic [15:0] w;
        w             = 16'h0000;
        w[B_PAR_EN]   = par;
        w[B_CLK_MODE] = mode;
        w[B_TX_START] = tx;
        w[B_RX_START] = rx;
        return w;
    endfunction
endpackage

/* verif/stc_link_asserts.sv */
// concurrent checks on the register port between host controller and self-test device
`timescale 1ns/1ps
`default_nettype none
module stc_link_asserts
#(
    parameter int RX_LONG_CYCLES = stc_pkg::RX_LONG_CYC
)(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // register port
    input  wire logic        sel,
    input  wire logic        wr,
    input  wire logic [8:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] rdata,
    input  wire logic        transfer_acknowledge,
    input  wire logic [7:0]  label_matrix_write_enable
);
    import stc_pkg::*;
    // ----------------------------------------
    // shadow of the written word and run timers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] shadow;
        logic        ran;
        logic        tx_run;
        logic        rx_run;
        logic        long_mode;
        logic [13:0] tx_cnt;
        logic [13:0] rx_cnt;
    } track_t;
    localparam logic [13:0] TX_LIM = 14'(TX_TEST_CYC);
    track_t      trk_r;
    track_t      trk_nxt;
    logic        wr_ack;
    logic        rd_ack;
    logic        tx_go;
    logic        rx_go;
    logic [13:0] rx_lim;
    assign wr_ack = transfer_acknowledge && wr;
    assign rd_ack = transfer_acknowledge && !wr;
    assign tx_go  = wr_ack && wdata[B_TX_START] && !trk_r.shadow[B_TX_START] && !trk_r.ran;
    assign rx_go  = wr_ack && wdata[B_RX_START] && !trk_r.shadow[B_RX_START] && !trk_r.ran;
    assign rx_lim = trk_r.long_mode ? 14'(RX_LONG_CYCLES) : 14'(RX_TEST_CYC);
    always_comb
    begin
        trk_nxt = trk_r;
        if (trk_r.tx_run && trk_r.tx_cnt != 14'h3FFF)
            trk_nxt.tx_cnt = trk_r.tx_cnt + 14'h0001;
        if (trk_r.rx_run && trk_r.rx_cnt != 14'h3FFF)
            trk_nxt.rx_cnt = trk_r.rx_cnt + 14'h0001;
        if (wr_ack)
            trk_nxt.shadow = wdata;
        if (tx_go)
            trk_nxt.tx_cnt = 14'h0000;
        if (rx_go)
            trk_nxt.rx_cnt = 14'h0000;
        trk_nxt.tx_run    = trk_r.tx_run | tx_go;
        trk_nxt.rx_run    = trk_r.rx_run | rx_go;
        trk_nxt.ran       = trk_r.ran | tx_go | rx_go;
        trk_nxt.long_mode = rx_go ? wdata[B_CLK_MODE] : trk_r.long_mode;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trk_r <= '0;
        else
            trk_r <= trk_nxt;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_ACK_LATENCY: assert property (
        sel && addr == ST_ADDR && !transfer_acknowledge |=> transfer_acknowledge)
        else $error("register request not acknowledged on the next cycle");
    AST_ACK_PULSE: assert property (
        transfer_acknowledge |=> !transfer_acknowledge [*2])
        else $error("acknowledge not a single pulse");
    AST_ACK_CAUSE: assert property (
        transfer_acknowledge |-> $past(sel) && sel && addr == ST_ADDR)
        else $error("acknowledge without a request");
    AST_REQ_HOLD: assert property (
        sel && !transfer_acknowledge |=> sel && $stable(wr) && $stable(wdata))
        else $error("request changed before acknowledge");
    AST_CFG_READBACK: assert property (
        rd_ack |-> {rdata[7:5], rdata[0]} == {trk_r.shadow[7:5], trk_r.shadow[0]})
        else $error("command bits read back wrong");
    AST_TX_RUNNING: assert property (
        rd_ack && trk_r.tx_run && trk_r.tx_cnt <= TX_LIM |-> rdata[10:8] == 3'h0)
        else $error("transmitter test ended early");
    AST_TX_DONE: assert property (
        rd_ack && trk_r.tx_run && trk_r.tx_cnt >= TX_LIM + 14'h0008 |-> rdata[13:8] == 6'h07)
        else $error("transmitter test not finished with pass");
    AST_RX_RUNNING: assert property (
        rd_ack && trk_r.rx_run && trk_r.rx_cnt <= rx_lim |-> !rdata[14])
        else $error("label matrix test ended early");
    AST_RX_DONE: assert property (
        rd_ack && trk_r.rx_run && trk_r.rx_cnt >= rx_lim + 14'h0008 |-> rdata[15:14] == 2'h1)
        else $error("label matrix test not finished with pass");
    AST_IDLE_CLEAR: assert property (
        rd_ack |-> (trk_r.tx_run || rdata[10:8] == 3'h0) && (trk_r.rx_run || !rdata[14]))
        else $error("completion shown without a started test");
    AST_LMWE_SET: assert property (
        rx_go |-> label_matrix_write_enable == 8'hFF)
        else $error("label matrix test started without all write enables");
    cover property (tx_go && rx_go);
    cover property (rx_go && wdata[B_CLK_MODE]);
    cover property (rd_ack && rdata[14]);
    cover property (rd_ack && rdata[8]);
endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench: apb host controller driving the self-test device
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import stc_pkg::*;
    localparam int RX_LONG = 1000;
    localparam int CEIL    = 20000;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic        rx_parity_error;
    logic        wrong_parity_clear;
    logic        parity_detect_enable;
    logic        wrong_parity_flag;
    logic [31:0] rd;
    int          fail_count;
    int          cmp_count;
    int          cyc;

    stc_link_if stc_link_if_inst ();
    self_test_host self_test_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq), .link(stc_link_if_inst.host));
    self_test_device #(.RX_LONG_CYCLES(RX_LONG)) self_test_device_inst (.pclk(pclk),
        .presetn(presetn), .link(stc_link_if_inst.device), .rx_parity_error(rx_parity_error),
        .wrong_parity_clear(wrong_parity_clear), .parity_detect_enable(parity_detect_enable),
        .wrong_parity_flag(wrong_parity_flag));
    stc_link_asserts #(.RX_LONG_CYCLES(RX_LONG)) stc_link_asserts_inst (.pclk(pclk),
        .presetn(presetn), .sel(stc_link_if_inst.sel), .wr(stc_link_if_inst.wr),
        .addr(stc_link_if_inst.addr), .wdata(stc_link_if_inst.wdata),
        .rdata(stc_link_if_inst.rdata),
        .transfer_acknowledge(stc_link_if_inst.transfer_acknowledge),
        .label_matrix_write_enable(stc_link_if_inst.label_matrix_write_enable));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, entered just after a rising edge; read data lands in rd
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic wait_en(input logic exp);
        for (int n = 0; n < 50 && parity_detect_enable !== exp; n++)
            @(posedge pclk);
        check("parity_detect_enable", 32'(exp), 32'(parity_detect_enable));
    endtask

    task automatic parity_pulse(input logic exp);
        rx_parity_error <= 1'b1;
        @(posedge pclk);
        rx_parity_error <= 1'b0;
        @(posedge pclk);
        check("wrong_parity_flag", 32'(exp), 32'(wrong_parity_flag));
        wrong_parity_clear <= 1'b1;
        @(posedge pclk);
        wrong_parity_clear <= 1'b0;
        @(posedge pclk);
        check("wrong_parity_flag cleared", 32'h0, 32'(wrong_parity_flag));
    endtask

    // start a run with done masked, poll, then unmask, see irq, clear it
    task automatic run_test(input logic [31:0] ctrl, input logic [7:0] res);
        apb(1'b1, H_IRQ_MSK, 32'h0);
        apb(1'b1, H_CTRL, ctrl);
        apb(1'b0, H_STATUS, 32'h0);
        check("busy", 32'h1, 32'(rd[0]));
        do
            apb(1'b0, H_STATUS, 32'h0);
        while (rd[0] === 1'b1);
        check("result", 32'(res), 32'(rd[31:24]));
        check("used", 32'h1, 32'(rd[1]));
        check("pslverr", 32'h0, 32'(pslverr));
        check("irq masked", 32'h0, 32'(irq));
        apb(1'b0, H_IRQ_STS, 32'h0);
        check("irq status", 32'h1, rd);
        apb(1'b1, H_IRQ_MSK, 32'h1);
        @(posedge pclk);
        check("irq unmasked", 32'h1, 32'(irq));
        apb(1'b1, H_IRQ_STS, 32'h1);
        @(posedge pclk);
        check("irq cleared", 32'h0, 32'(irq));
    endtask

    // ----------------------------------------
    // sequence and timeout
    // ----------------------------------------
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == CEIL)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rx_parity_error = 1'b0;
        wrong_parity_clear = 1'b0;
        fail_count = 0;
        cmp_count = 0;
        cyc = 0;
        do_reset();
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset value", 32'h0, rd);
        end
        parity_pulse(1'b0);
        apb(1'b1, H_CTRL, 32'h1);
        wait_en(1'b1);
        parity_pulse(1'b1);
        apb(1'b1, 8'h10, 32'hF);
        apb(1'b0, H_CTRL, 32'h0);
        check("ctrl", 32'h1, rd);
        apb(1'b1, H_CTRL, 32'h0);
        wait_en(1'b0);
        parity_pulse(1'b0);
        run_test(32'hC, 8'h47);
        apb(1'b1, H_CTRL, 32'h4);
        apb(1'b0, H_IRQ_STS, 32'h0);
        check("refused", 32'h2, rd);
        apb(1'b0, H_STATUS, 32'h0);
        check("result kept", 32'h47, 32'(rd[31:24]));
        do_reset();
        run_test(32'hA, 8'h40);
        do_reset();
        run_test(32'h5, 8'h07);
        wait_en(1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
